// ==== logic/etimer_pkg.sv ====
// constants for the ten-bit enhanced timer core
package etimer_pkg;
  localparam int CNT_W  = 10;
  localparam int PER_W  = 3;
  localparam int BYTE_W = 8;

  // apb byte addresses, one word per register
  localparam logic [7:0] ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_CTRL2  = 8'h08;
  localparam logic [7:0] ADDR_CNT_LO = 8'h0c;
  localparam logic [7:0] ADDR_CNT_HI = 8'h10;
  localparam logic [7:0] ADDR_A_LO   = 8'h14;
  localparam logic [7:0] ADDR_A_HI   = 8'h18;
  localparam logic [7:0] ADDR_B_LO   = 8'h1c;
  localparam logic [7:0] ADDR_B_HI   = 8'h20;

  // control zero fields
  localparam int CTL0_PAUSE   = 7;
  localparam int CTL0_CLK_LSB = 4;
  localparam int CTL0_RUN     = 3;
  localparam int CTL0_PER_LSB = 0;
  // channel control fields (control one and two)
  localparam int CTL_MODE_LSB = 6;
  localparam int CTL_IO_LSB   = 4;
  localparam int CTL_OC       = 3;
  localparam int CTL_POL      = 2;
  localparam int CTL1_DIR     = 1;
  localparam int CTL1_CLR     = 0;
  localparam int CTL2_ALN_LSB = 0;

  localparam logic [7:0]       CTRL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RESET  = 10'h000;
  localparam logic [CNT_W-1:0] CNT_RESET  = 10'h000;

  // counter clock select codes
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS  = 3'h1;
  localparam logic [2:0] CK_H16  = 3'h2;
  localparam logic [2:0] CK_H64  = 3'h3;
  localparam logic [2:0] CK_SUB  = 3'h4;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;

  // prescaler masks for the divide-by-4, 16 and 64 taps
  localparam logic [5:0] PRE_MASK4  = 6'h03;
  localparam logic [5:0] PRE_MASK16 = 6'h0f;
  localparam logic [5:0] PRE_MASK64 = 6'h3f;
  localparam int         SUB_DIV    = 6250;

  // channel modes and io codes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] IO_0     = 2'h0;
  localparam logic [1:0] IO_1     = 2'h1;
  localparam logic [1:0] IO_2     = 2'h2;
  localparam logic [1:0] IO_3     = 2'h3;
endpackage

// ==== logic/count_tick_if.sv ====
// carrier between the timer core and its count clock source
interface count_tick_if;
  logic [2:0] clockSel;
  logic       tick;
  logic       extRise;

  modport source (
    input  clockSel,
    output tick,
    output extRise
  );
  modport sink (
    output clockSel,
    input  tick,
    input  extRise
  );
endinterface

// ==== logic/count_clock_gen.sv ====
// count clock source: prescaler taps, sub clock divider, external pin edges
module count_clock_gen
  import etimer_pkg::*;
#(
  parameter int SUB_CLOCK_DIV = SUB_DIV
) (
  input wire logic   clock,
  input wire logic   reset,
  input wire logic   extPin,
  count_tick_if.source tk
);
  logic [5:0]  pre_reg,  pre_next;
  logic [15:0] sub_reg,  sub_next;
  logic        extPrev_reg, extPrev_next;
  logic        subTick;
  logic        extFall;

  // free running prescaler and sub clock divider
  always_comb begin
    pre_next     = pre_reg + 6'h01;
    subTick      = (sub_reg == 16'(SUB_CLOCK_DIV - 1));
    sub_next     = subTick ? 16'h0000 : sub_reg + 16'h0001;
    extPrev_next = extPin;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pre_reg     <= 6'h00;
      sub_reg     <= 16'h0000;
      extPrev_reg <= 1'b0;
    end else begin
      pre_reg     <= pre_next;
      sub_reg     <= sub_next;
      extPrev_reg <= extPrev_next;
    end
  end

  // pin is synchronous to clock, so edges come straight off one flop
  assign tk.extRise = extPin & ~extPrev_reg;
  assign extFall    = ~extPin & extPrev_reg;

  always_comb begin
    case (tk.clockSel)
      CK_SYS4: tk.tick = ((pre_reg & PRE_MASK4) == PRE_MASK4);
      CK_SYS:  tk.tick = 1'b1;
      CK_H16:  tk.tick = ((pre_reg & PRE_MASK16) == PRE_MASK16);
      CK_H64:  tk.tick = ((pre_reg & PRE_MASK64) == PRE_MASK64);
      CK_SUB:  tk.tick = subTick;
      CK_EXTR: tk.tick = tk.extRise;
      CK_EXTF: tk.tick = extFall;
      default: tk.tick = 1'b0; // undefined code: counter never advances
    endcase
  end
endmodule

// ==== logic/enhanced_timer.sv ====
// ten-bit enhanced timer core with apb register access
module enhanced_timer
  import etimer_pkg::*;
#(
  parameter int SUB_CLOCK_DIV = SUB_DIV
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        externalCountClockPin,
  input  wire logic        captureInA,
  input  wire logic        captureInB,
  output logic      [1:0]  channelAOutputPins,
  output logic      [2:0]  channelBOutputPins,
  output logic             compareAEvent,
  output logic             compareBEvent,
  output logic             periodEvent
);
  logic [7:0]       ctrl0_reg, ctrl0_next;
  logic [7:0]       ctrl1_reg, ctrl1_next;
  logic [7:0]       ctrl2_reg, ctrl2_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             dir_reg, dir_next;
  logic             runPrev_reg, runPrev_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic             pready_reg, pready_next;
  logic             pslverr_reg, pslverr_next;
  logic [1:0]       pinA_reg, pinA_next;
  logic [2:0]       pinB_reg, pinB_next;
  logic             evA_reg, evA_next;
  logic             evB_reg, evB_next;
  logic             evP_reg, evP_next;

  logic [CNT_W-1:0] cmpVal [2];
  logic [1:0]       chMatch;
  logic [1:0]       chCapture;
  logic [1:0]       chLevel;
  logic [1:0]       chLoWr;
  logic [1:0]       chHiWr;

  logic             wrDone;
  logic             rdDone;
  logic [7:0]       wrByte;
  logic             runBit;
  logic             pauseBit;
  logic             runRise;
  logic             counting;
  logic [CNT_W:0]   cntStep;
  logic             matchP;
  logic             clearHit;
  logic             centre;
  logic             singlePulse;
  logic             pulseStop;
  logic             extTrigger;
  logic             mapped;
  logic [31:0]      readMux;

  count_tick_if tk ();

  count_clock_gen #(
    .SUB_CLOCK_DIV (SUB_CLOCK_DIV)
  ) u_clock_gen (
    .clock  (clock),
    .reset  (reset),
    .extPin (externalCountClockPin),
    .tk     (tk)
  );

  // bus handshake: one wait state, so read data comes from a flop
  assign wrDone = psel & penable & pready_reg & pwrite & pstrb[0];
  assign rdDone = psel & penable & pready_reg & ~pwrite;
  assign wrByte = pwdata[7:0];

  always_comb begin
    pready_next = psel & penable & ~pready_reg;
  end

  // control byte fields steer the core
  assign runBit      = ctrl0_reg[CTL0_RUN];
  assign pauseBit    = ctrl0_reg[CTL0_PAUSE];
  assign tk.clockSel = ctrl0_reg[CTL0_CLK_LSB +: 3];
  assign runRise     = runBit & ~runPrev_reg;
  // pause freezes the count without touching it
  assign counting    = runBit & ~pauseBit & tk.tick;

  // single pulse is pwm mode with io code three on channel a
  assign singlePulse = (ctrl1_reg[CTL_MODE_LSB +: 2] == MODE_PWM)
                     & (ctrl1_reg[CTL_IO_LSB +: 2] == IO_3);
  // centre aligned pwm counts back down instead of clearing
  assign centre      = (ctrl1_reg[CTL_MODE_LSB +: 2] == MODE_PWM)
                     & (ctrl2_reg[CTL2_ALN_LSB +: 2] != 2'h0) & ~singlePulse;

  // next count value in the present direction
  assign cntStep = dir_reg ? {1'b0, cnt_reg} - 11'h001 : {1'b0, cnt_reg} + 11'h001;

  // period match on top bits; code zero lands on 1024, the overflow
  // match every 128 times the period code
  assign matchP = counting & ~dir_reg
                & (cntStep[CNT_W-1:CNT_W-PER_W] == ctrl0_reg[CTL0_PER_LSB +: PER_W])
                & (cntStep[CNT_W-PER_W-1:0] == 7'h00);

  // clear source; capture, and pwm other than single pulse, always clear on period
  always_comb begin
    case (ctrl1_reg[CTL_MODE_LSB +: 2])
      MODE_PWM: clearHit = singlePulse ? 1'b0 : matchP;
      MODE_CAP: clearHit = matchP;
      default:  clearHit = ctrl1_reg[CTL1_CLR] ? chMatch[0] : matchP;
    endcase
  end

  // counter, cleared on run rise, frozen while run is low
  // no software path writes the count directly
  always_comb begin
    cnt_next     = cnt_reg;
    dir_next     = dir_reg;
    runPrev_next = runBit;
    if (runRise) begin
      cnt_next = CNT_RESET;
      dir_next = 1'b0;
    end else if (counting) begin
      if (dir_reg) begin
        cnt_next = cntStep[CNT_W-1:0];
        if (cnt_reg == 10'h001) begin
          dir_next = 1'b0;
        end
      end else if (clearHit && centre) begin
        cnt_next = cnt_reg - 10'h001;
        dir_next = 1'b1;
      end else if (clearHit) begin
        cnt_next = CNT_RESET;
      end else begin
        cnt_next = cntStep[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_reg     <= CNT_RESET;
      dir_reg     <= 1'b0;
      runPrev_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      dir_reg     <= dir_next;
      runPrev_reg <= runPrev_next;
    end
  end

  // single pulse: external edge starts the pulse, match a ends it
  assign extTrigger = singlePulse & tk.extRise;
  assign pulseStop  = singlePulse & chMatch[0];

  // control registers; a hardware set of run wins over a software write
  always_comb begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    if (wrDone && paddr == ADDR_CTRL0) begin
      ctrl0_next = wrByte;
    end else if (pulseStop) begin
      ctrl0_next[CTL0_RUN] = 1'b0;
    end
    if (extTrigger) begin
      ctrl0_next[CTL0_RUN] = 1'b1;
    end
    if (wrDone && paddr == ADDR_CTRL1) begin
      ctrl1_next = wrByte;
    end
    // direction flag is read only and follows the counter
    ctrl1_next[CTL1_DIR] = dir_next;
    if (wrDone && paddr == ADDR_CTRL2) begin
      ctrl2_next = wrByte;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl0_reg <= CTRL_RESET;
      ctrl1_reg <= CTRL_RESET;
      ctrl2_reg <= CTRL_RESET;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  assign chLoWr[0] = wrDone & (paddr == ADDR_A_LO);
  assign chHiWr[0] = wrDone & (paddr == ADDR_A_HI);
  assign chLoWr[1] = wrDone & (paddr == ADDR_B_LO);
  assign chHiWr[1] = wrDone & (paddr == ADDR_B_HI);

  // per channel compare value, comparator, capture and pin level
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [7:0]       ctl;
    logic [CNT_W-1:0] cmp_reg, cmp_next;
    logic             lvl_reg, lvl_next;
    logic             capPrev_reg, capPrev_next;
    logic             capIn;
    logic             capRise;
    logic             capFall;
    logic             active;

    assign ctl     = (i == 0) ? ctrl1_reg : ctrl2_reg;
    assign capIn   = (i == 0) ? captureInA : captureInB;
    assign capRise = capIn & ~capPrev_reg;
    assign capFall = ~capIn & capPrev_reg;

    // comparator runs on every count step
    assign chMatch[i] = counting & (cntStep[CNT_W-1:0] == cmp_reg) & ~cntStep[CNT_W];

    // capture edge select; code three disables capture
    always_comb begin
      chCapture[i] = 1'b0;
      if (ctl[CTL_MODE_LSB +: 2] == MODE_CAP && runBit) begin
        case (ctl[CTL_IO_LSB +: 2])
          IO_0:    chCapture[i] = capRise;
          IO_1:    chCapture[i] = capFall;
          IO_2:    chCapture[i] = capRise | capFall;
          default: chCapture[i] = 1'b0;
        endcase
      end
    end

    // compare byte pair written by software
    // same layout for channel b; capture wins over a write
    always_comb begin
      cmp_next     = cmp_reg;
      capPrev_next = capIn;
      if (chLoWr[i]) begin
        cmp_next[7:0] = wrByte;
      end
      if (chHiWr[i]) begin
        cmp_next[9:8] = wrByte[1:0];
      end
      if (chCapture[i]) begin
        cmp_next = cnt_reg;
      end
    end

    // pwm duty: active while the count sits below the compare value
    assign active = (cnt_reg < cmp_reg);

    always_comb begin
      lvl_next = lvl_reg;
      case (ctl[CTL_MODE_LSB +: 2])
        MODE_CMP: begin
          if (runRise) begin
            lvl_next = ctl[CTL_OC];
          end else if (chMatch[i]) begin
            case (ctl[CTL_IO_LSB +: 2])
              IO_1:    lvl_next = 1'b0;
              IO_2:    lvl_next = 1'b1;
              IO_3:    lvl_next = ~lvl_reg;
              default: lvl_next = lvl_reg;
            endcase
          end
        end
        MODE_PWM: begin
          case (ctl[CTL_IO_LSB +: 2])
            IO_0:    lvl_next = ~ctl[CTL_OC];
            IO_1:    lvl_next = ctl[CTL_OC];
            IO_2:    lvl_next = active ? ctl[CTL_OC] : ~ctl[CTL_OC];
            default: lvl_next = runBit ? ctl[CTL_OC] : ~ctl[CTL_OC];
          endcase
        end
        default: lvl_next = 1'b0; // capture and timer hold the level low
      endcase
    end

    always_ff @(posedge clock) begin
      if (reset) begin
        cmp_reg     <= CMP_RESET;
        lvl_reg     <= 1'b0;
        capPrev_reg <= 1'b0;
      end else begin
        cmp_reg     <= cmp_next;
        lvl_reg     <= lvl_next;
        capPrev_reg <= capPrev_next;
      end
    end

    assign cmpVal[i]  = cmp_reg;
    // polarity inversion has no effect in timer mode
    assign chLevel[i] = (ctl[CTL_MODE_LSB +: 2] == MODE_TMR) ? 1'b0
                      : lvl_reg ^ ctl[CTL_POL];
  end

  // one level fans out to the channel's pins
  // interrupt requests as registered one-cycle pulses
  always_comb begin
    pinA_next = {2{chLevel[0]}};
    pinB_next = {3{chLevel[1]}};
    evA_next  = chMatch[0] | chCapture[0];
    evB_next  = chMatch[1] | chCapture[1];
    evP_next  = matchP;
  end

  // read decode; unmapped addresses answer an error with zero data
  always_comb begin
    mapped  = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      ADDR_CTRL0:  readMux[7:0] = ctrl0_reg;
      ADDR_CTRL1:  readMux[7:0] = ctrl1_reg;
      ADDR_CTRL2:  readMux[7:0] = ctrl2_reg;
      ADDR_CNT_LO: readMux[7:0] = cnt_reg[7:0];
      ADDR_CNT_HI: readMux[1:0] = cnt_reg[9:8];
      ADDR_A_LO:   readMux[7:0] = cmpVal[0][7:0];
      ADDR_A_HI:   readMux[1:0] = cmpVal[0][9:8];
      ADDR_B_LO:   readMux[7:0] = cmpVal[1][7:0];
      ADDR_B_HI:   readMux[1:0] = cmpVal[1][9:8];
      default:     mapped = 1'b0;
    endcase
    prdata_next  = pready_next ? readMux : 32'h00000000;
    pslverr_next = pready_next & ~mapped;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      pinA_reg    <= 2'h0;
      pinB_reg    <= 3'h0;
      evA_reg     <= 1'b0;
      evB_reg     <= 1'b0;
      evP_reg     <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      pinA_reg    <= pinA_next;
      pinB_reg    <= pinB_next;
      evA_reg     <= evA_next;
      evB_reg     <= evB_next;
      evP_reg     <= evP_next;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign channelAOutputPins = pinA_reg;
  assign channelBOutputPins = pinB_reg;
  assign compareAEvent      = evA_reg;
  assign compareBEvent      = evB_reg;
  assign periodEvent        = evP_reg;

  // read strobe unused: reads have no side effect in this core
  logic unusedRd;
  assign unusedRd = rdDone;
endmodule

// ==== bench/ext_clock_model.sv ====
// far-side model of the external count clock pin
module ext_clock_model (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic enable,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;

  // square wave, six clocks a period
  // rests low while idle so no stray edges reach the counter
  always_ff @(posedge clock) begin
    if (reset || !enable) begin
      phase <= 2'h0;
      pin <= 1'b0;
    end else if (phase == 2'h2) begin
      phase <= 2'h0;
      pin <= ~pin;
    end else begin
      phase <= phase + 2'h1;
    end
  end
endmodule

// ==== bench/enhanced_timer_sva.sv ====
// port-level assertions for the enhanced timer core
module enhanced_timer_sva
  import etimer_pkg::*;
#(
  parameter int SUB_CLOCK_DIV = SUB_DIV
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        externalCountClockPin,
  input wire logic        captureInA,
  input wire logic        captureInB,
  input wire logic [1:0]  channelAOutputPins,
  input wire logic [2:0]  channelBOutputPins,
  input wire logic        compareAEvent,
  input wire logic        compareBEvent,
  input wire logic        periodEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // address decode of the register map
  wire logic mapped = paddr inside {ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2, ADDR_CNT_LO,
    ADDR_CNT_HI, ADDR_A_LO, ADDR_A_HI, ADDR_B_LO, ADDR_B_HI};
  wire logic hiByte = paddr inside {ADDR_CNT_HI, ADDR_A_HI, ADDR_B_HI};

  hi_bits_zero_a: assert property (pready && hiByte |-> prdata[7:2] == 6'h00)
    else $error("high byte upper bits not zero");
  byte_only_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  one_wait_a: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  pins_a_even_a: assert property (channelAOutputPins == 2'h0 || channelAOutputPins == 2'h3)
    else $error("channel a pins disagree");
  pins_b_even_a: assert property (channelBOutputPins == 3'h0 || channelBOutputPins == 3'h7)
    else $error("channel b pins disagree");
  period_gap_a: assert property (periodEvent |=> !periodEvent [*8])
    else $error("period matches too close");
  a_pulse_a: assert property (compareAEvent |=> !compareAEvent)
    else $error("compare a request not a pulse");
  // reset itself is the cause here, so no disable
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> prdata == 32'h0 && !pready
    && !periodEvent && !compareAEvent && !compareBEvent && channelAOutputPins == 2'h0)
    else $error("outputs not quiet after reset");

  cover property (periodEvent);
  cover property (compareAEvent);
  cover property (compareBEvent);
  cover property (pready && pslverr);
endmodule

bind enhanced_timer enhanced_timer_sva #(.SUB_CLOCK_DIV(SUB_CLOCK_DIV)) sva (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .externalCountClockPin(externalCountClockPin),
  .captureInA(captureInA), .captureInB(captureInB),
  .channelAOutputPins(channelAOutputPins), .channelBOutputPins(channelBOutputPins),
  .compareAEvent(compareAEvent), .compareBEvent(compareBEvent), .periodEvent(periodEvent));

// ==== bench/enhanced_timer_tb_top.sv ====
// self-checking bench for the enhanced timer core
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module enhanced_timer_tb_top import etimer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SUBDIV = 4;
  localparam int LIMIT  = 20000;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic        extEnable, extPin, evA, evB, evP, capIn;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  pinsA;
  logic [2:0]  pinsB;
  int          fail_count, n_checks;

  enhanced_timer #(.SUB_CLOCK_DIV(SUBDIV)) DUT (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalCountClockPin(extPin), .captureInA(capIn),
    .captureInB(capIn), .channelAOutputPins(pinsA), .channelBOutputPins(pinsB),
    .compareAEvent(evA), .compareBEvent(evB), .periodEvent(evP));
  ext_clock_model PIN (.clock(clock), .reset(reset), .enable(extEnable), .pin(extPin));

  // free-running 200 MHz clock
  always #2.5 clock = ~clock;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up;
    fail_count++;
    tally_and_finish();
  endtask

  // one apb transfer; an idle cycle follows so strobes never retoggle in one step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (n >= 50) give_up();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0, 4'hf);
  endtask

  function automatic logic pick(input int k);
    return k == 0 ? evP : (k == 1 ? evA : evB);
  endfunction

  // edges between two successive requests of one kind
  task automatic gap_of(input int k, output int gap);
    int n;
    n = 0;
    // skip a request still launched under the previous settings
    @(posedge clock);
    while (pick(k) !== 1'b1 && n < LIMIT) begin
      @(posedge clock);
      n++;
    end
    gap = 0;
    do begin
      @(posedge clock);
      gap++;
    end while (pick(k) !== 1'b1 && gap < LIMIT);
    if (n >= LIMIT || gap >= LIMIT) give_up();
  endtask

  task automatic s_reset_values;
    logic [7:0] addrs [9] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2, ADDR_CNT_LO,
      ADDR_CNT_HI, ADDR_A_LO, ADDR_A_HI, ADDR_B_LO, ADDR_B_HI};
    foreach (addrs[i]) begin
      rd(addrs[i]);
      `CHK(rdat, 32'h0)
      `CHK(rerr, 1'b0)
    end
  endtask

  // every clock code but the dead 101, and the overflow period, measured between period requests
  task automatic s_clock_rates;
    logic [7:0] ctl [8] = '{8'h09, 8'h19, 8'h29, 8'h39, 8'h49, 8'h69, 8'h79, 8'h18};
    int         expGap [8] = '{4 * 128, 128, 16 * 128, 64 * 128, SUBDIV * 128,
      6 * 128, 6 * 128, 1024};
    int         g;
    foreach (ctl[i]) begin
      extEnable <= ctl[i][6] & ctl[i][5];
      wr(ADDR_CTRL0, {24'h0, ctl[i]});
      gap_of(0, g);
      `CHK(g, expGap[i])
    end
    extEnable <= 1'b0;
  endtask

  // run fall holds, counter write ignored, run rise clears, code 101 is dead
  task automatic s_run_hold;
    logic [31:0] first;
    wr(ADDR_CTRL0, 32'h10);
    rd(ADDR_CNT_LO);
    first = rdat;
    wr(ADDR_CNT_LO, 32'h55);
    repeat (20) @(posedge clock);
    rd(ADDR_CNT_LO);
    `CHK(rdat, first)
    wr(ADDR_CTRL0, 32'h58);
    rd(ADDR_CNT_LO);
    `CHK(rdat, 32'h0)
    rd(ADDR_CNT_HI);
    `CHK(rdat, 32'h0)
  endtask

  task automatic s_pause;
    logic [31:0] first;
    wr(ADDR_CTRL0, 32'h18);
    wr(ADDR_CTRL0, 32'h98);
    rd(ADDR_CNT_LO);
    first = rdat;
    rd(ADDR_CNT_LO);
    `CHK(rdat, first)
    wr(ADDR_CTRL0, 32'h18);
    rd(ADDR_CNT_LO);
    `CHK(rdat == first, 1'b0)
  endtask

  // clear on a ten-bit compare a, one compare b request per lap
  task automatic s_compare;
    int g;
    int nb;
    wr(ADDR_CTRL1, 32'hc1);
    wr(ADDR_CTRL2, 32'hc0);
    wr(ADDR_A_HI, 32'h01);
    wr(ADDR_A_LO, 32'h05);
    wr(ADDR_B_LO, 32'h05);
    gap_of(1, g);
    `CHK(g, 261)
    nb = 0;
    repeat (261) begin
      @(posedge clock);
      if (evB === 1'b1) nb++;
    end
    `CHK(nb, 1)
    rd(ADDR_A_HI);
    `CHK(rdat, 32'h1)
  endtask

  // unused high bits, strobe-less write, unmapped place, read-only direction
  task automatic s_edges;
    wr(ADDR_B_HI, 32'hffffffff);
    rd(ADDR_B_HI);
    `CHK(rdat, 32'h3)
    apb(ADDR_B_LO, 1'b1, 32'haa, 4'h0);
    rd(ADDR_B_LO);
    `CHK(rdat, 32'h5)
    rd(8'h24);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
    wr(ADDR_CTRL1, 32'hff);
    rd(ADDR_CTRL1);
    `CHK(rdat, 32'hfd)
  endtask

  // forced pwm levels with polarity, then compare output driven low on match a
  task automatic s_pins;
    int g;
    wr(ADDR_CTRL1, 32'h98);
    wr(ADDR_CTRL2, 32'h98);
    repeat (2) @(posedge clock);
    `CHK(pinsA, 2'h3)
    `CHK(pinsB, 3'h7)
    wr(ADDR_CTRL2, 32'h9c);
    repeat (2) @(posedge clock);
    `CHK(pinsB, 3'h0)
    wr(ADDR_CTRL1, 32'h18);
    wr(ADDR_CTRL0, 32'h10);
    wr(ADDR_CTRL0, 32'h18);
    repeat (2) @(posedge clock);
    `CHK(pinsA, 2'h3)
    gap_of(1, g);
    `CHK(g, 1024)
    @(posedge clock);
    `CHK(pinsA, 2'h0)
  endtask

  // paused counter latched into both compare registers on a rising edge
  task automatic s_capture;
    logic [31:0] lo;
    wr(ADDR_CTRL1, 32'h40);
    wr(ADDR_CTRL2, 32'h40);
    wr(ADDR_CTRL0, 32'h98);
    rd(ADDR_CNT_LO);
    lo = rdat;
    capIn <= 1'b1;
    repeat (2) @(posedge clock);
    capIn <= 1'b0;
    rd(ADDR_A_LO);
    `CHK(rdat, lo)
    rd(ADDR_B_LO);
    `CHK(rdat, lo)
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    extEnable = 1'b0;
    capIn = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    s_reset_values();
    s_clock_rates();
    s_run_hold();
    s_pause();
    s_compare();
    s_edges();
    s_pins();
    s_capture();
    tally_and_finish();
  end
endmodule
